// *** rtl/spl_top.sv ***
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/100ps
// Function
// R1 - when chip reset is released the level on the receive-error pin is kept as emission_filter_strap.
// R2 - when chip reset is released the level on the data-valid pin is kept as config_strap_bit2.
// R3 - when chip reset is released receive data bit three is kept as phy_addr_strap_bit0.
// R4 - strap pins are inputs while reset is active and are driven as outputs afterwards.
// R5 - receive data outputs change only on the receive clock the device drives.
// R6 - nibbles are valid only while the data-valid output is high and are held valid all through it.
// R7 - in MDI mode pair a transmits and pair b receives, and MDI-X swaps the roles.
// R8 - the management data line is sampled and driven with the management clock from outside.
// R9 - when chip reset is released receive data bits two and one become address bits one and two.
// R10 - when chip reset is released the receive clock pin and carrier pin become config bits zero and one.
// R11 - the outside system holds chip reset low, and straps are taken as it returns high.
// R12 - latched straps stay fixed until the next reset whatever the shared pins do later; management_phy_address bits above PA_BIT2 follow REG_CTRL writes in run.
module spl_top
  import spl_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      rst_b,
  input  wire logic                      rx_link_clk,
  // register port
  input  wire logic [spl_pkg::REG_AW-1:0] reg_addr,
  input  wire logic [spl_pkg::REG_DW-1:0] reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [spl_pkg::REG_DW-1:0] reg_rdata,
  // receive stream from the line side, on the link clock
  input  wire logic [spl_pkg::NIB_W-1:0] line_rx_nib,
  input  wire logic                      line_rx_valid,
  input  wire logic                      line_rx_err,
  input  wire logic                      line_carrier,
  // shared strap / MII pins: input, output, output enable (low = driving)
  input  wire logic [spl_pkg::NIB_W-1:0] rxd_in,
  output logic      [spl_pkg::NIB_W-1:0] rxd_out,
  output logic      [spl_pkg::NIB_W-1:0] rxd_oe_b,
  input  wire logic                      rxdv_in,
  output logic                           rxdv_out,
  output logic                           rxdv_oe_b,
  input  wire logic                      rxer_in,
  output logic                           rxer_out,
  output logic                           rxer_oe_b,
  input  wire logic                      rxc_in,
  output logic                           rxc_out,
  output logic                           rxc_oe_b,
  input  wire logic                      crs_in,
  output logic                           crs_out,
  output logic                           crs_oe_b,
  // line pair role select
  output logic                           pair_a_is_tx,
  output logic                           pair_b_is_tx,
  // management data pin
  input  wire logic                      mdc,
  input  wire logic                      mdio_in,
  input  wire logic                      mdio_tx_bit,
  input  wire logic                      mdio_tx_en,
  output logic                           mdio_out,
  output logic                           mdio_oe_b,
  output logic                           mdio_sample,
  // latched straps
  output logic                           emission_filter_strap,
  output logic      [spl_pkg::CFG_W-1:0]  config_strap,
  output logic      [spl_pkg::ADDR_W-1:0] management_phy_address
);
  import spl_pkg::*;

  // ------------------------------------------------------------
  // strap pins synchronised before use
  // ------------------------------------------------------------
  localparam int unsigned SW = NIB_W + 4;
  logic [SW-1:0] strap_raw;
  logic [SW-1:0] strap_s;
  assign strap_raw = {rxd_in, rxdv_in, rxer_in, rxc_in, crs_in};

  spl_sync #(.W(SW)) u_strap_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .d     (strap_raw),
    .q     (strap_s)
  );

  // ------------------------------------------------------------
  // strap phase: pins are inputs in reset, captured after release
  // ------------------------------------------------------------
  spl_phase_t phase_reg;
  spl_phase_t phase_next;
  // two edges of settling so the synchroniser holds post-release pin levels
  logic [1:0] settle_reg;
  logic       capture;

  always_comb begin
    phase_next = phase_reg;
    case (phase_reg)
      SPL_STRAP: phase_next = SPL_ARM;
      SPL_ARM:   if (settle_reg == 2'h1) phase_next = SPL_RUN;
      SPL_RUN:   phase_next = SPL_RUN;
      default:   phase_next = SPL_STRAP;
    endcase
  end

  assign capture = (phase_reg == SPL_ARM) && (settle_reg == 2'h1);

  always_ff @(posedge clk) begin
    if (!rst_b) begin // see R11
      phase_reg  <= SPL_STRAP;
      settle_reg <= 2'h0;
    end else begin
      phase_reg  <= phase_next;
      settle_reg <= (phase_reg == SPL_ARM) ? settle_reg + 2'h1 : 2'h0;
    end
  end

  // ------------------------------------------------------------
  // strap latches, written once per reset; address bits above PA_BIT2 reload from pa_hi_reg every run cycle
  // ------------------------------------------------------------
  logic [ADDR_W-1:0] pa_hi_reg;
  logic [ADDR_W-1:0] pa_cap;
  assign pa_cap = {2'b00,
                   strap_s[4 + RXD_B1],
                   strap_s[4 + RXD_B2],
                   strap_s[4 + RXD_B3]};

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      emission_filter_strap  <= 1'b0;
      config_strap           <= CFG_ZERO;
      management_phy_address <= ADDR_ZERO;
    end else if (capture) begin // see R12
      emission_filter_strap          <= strap_s[2]; // see R1
      config_strap[CFG_BIT2]         <= strap_s[3]; // see R2
      config_strap[CFG_BIT0]         <= strap_s[1]; // see R10
      config_strap[CFG_BIT1]         <= strap_s[0]; // see R10
      management_phy_address[PA_BIT0] <= pa_cap[PA_BIT0]; // see R3
      management_phy_address[PA_BIT1] <= pa_cap[PA_BIT1]; // see R9
      management_phy_address[PA_BIT2] <= pa_cap[PA_BIT2]; // see R9
    end else if (phase_reg == SPL_RUN) begin
      management_phy_address[ADDR_W-1:PA_BIT2+1] <= pa_hi_reg[ADDR_W-1:PA_BIT2+1];
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic mdix_reg;
  logic wr_ctrl;
  logic [REG_DW-1:0] rd_mux;
  assign wr_ctrl = reg_wr && (reg_addr == REG_CTRL);
  assign rd_mux =
    (reg_addr == REG_STRAP)  ? {{(REG_DW-ADDR_W-CFG_W-1){1'b0}}, management_phy_address,
                                config_strap, emission_filter_strap} :
    (reg_addr == REG_CTRL)   ? {{(REG_DW-ADDR_W-1){1'b0}}, pa_hi_reg[ADDR_W-1:PA_BIT2+1],
                                3'b000, mdix_reg} :
    (reg_addr == REG_STATUS) ? {{(REG_DW-2){1'b0}}, phase_reg} :
    DATA_ZERO;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mdix_reg  <= 1'b0;
      pa_hi_reg <= ADDR_ZERO;
      reg_rdata <= DATA_ZERO;
    end else begin
      if (wr_ctrl) begin
        mdix_reg  <= reg_wdata[CTRL_MDIX];
        pa_hi_reg <= {reg_wdata[CTRL_PA_HI_LSB+3:CTRL_PA_HI_LSB+2], 3'b000};
      end
      reg_rdata <= reg_rd ? rd_mux : DATA_ZERO;
    end
  end

  // ------------------------------------------------------------
  // line pair roles
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pair_a_is_tx <= 1'b1;
      pair_b_is_tx <= 1'b0;
    end else begin
      pair_a_is_tx <= !mdix_reg; // see R7
      pair_b_is_tx <= mdix_reg;  // see R7
    end
  end

  // ------------------------------------------------------------
  // run flag crosses into link domain as a level
  // ------------------------------------------------------------
  logic run_lvl_reg;
  logic run_link;
  logic link_rst_b;
  always_ff @(posedge clk) begin
    if (!rst_b) run_lvl_reg <= 1'b0;
    else        run_lvl_reg <= (phase_reg == SPL_RUN);
  end

  // the level goes through the data path only, so just the second stage feeds the link logic
  spl_sync #(.W(1)) u_run_sync (
    .clk   (rx_link_clk),
    .rst_b (1'b1),
    .d     (run_lvl_reg),
    .q     (run_link)
  );
  assign link_rst_b = run_link;

  // ------------------------------------------------------------
  // receive outputs on the link clock
  // ------------------------------------------------------------
  logic link_drive;
  assign link_drive = (phase_reg == SPL_RUN);

  always_ff @(posedge rx_link_clk) begin
    if (!link_rst_b) begin
      rxd_out  <= NIB_ZERO;
      rxdv_out <= 1'b0;
      rxer_out <= 1'b0;
      crs_out  <= 1'b0;
    end else begin
      // data passes only with valid and is zero outside it, so the nibble is only frame data
      rxd_out  <= line_rx_valid ? line_rx_nib : NIB_ZERO; // see R5, R6
      rxdv_out <= line_rx_valid; // see R6
      rxer_out <= line_rx_valid & line_rx_err;
      crs_out  <= line_carrier;
    end
  end

  // enables sit on clk: a link-domain release would lag reset by several link
  // cycles and the straps would then latch our own driven levels
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rxd_oe_b  <= {NIB_W{1'b1}};
      rxdv_oe_b <= 1'b1;
      rxer_oe_b <= 1'b1;
      rxc_oe_b  <= 1'b1;
      crs_oe_b  <= 1'b1;
    end else begin
      rxd_oe_b  <= {NIB_W{!link_drive}}; // see R4
      rxdv_oe_b <= !link_drive; // see R4
      rxer_oe_b <= !link_drive;
      rxc_oe_b  <= !link_drive;
      crs_oe_b  <= !link_drive;
    end
  end

  // receive clock copy from a flop: toggles each link edge, half rate
  always_ff @(posedge rx_link_clk) begin
    if (!link_rst_b) rxc_out <= 1'b0;
    else             rxc_out <= !rxc_out; // see R5
  end

  // ------------------------------------------------------------
  // management data on its own clock
  // ------------------------------------------------------------
  always_ff @(posedge mdc) begin
    if (!rst_b) begin
      mdio_out    <= 1'b1;
      mdio_oe_b   <= 1'b1;
      mdio_sample <= 1'b0;
    end else begin
      mdio_sample <= mdio_in; // see R8
      mdio_out    <= mdio_tx_bit; // see R8
      mdio_oe_b   <= !mdio_tx_en;
    end
  end

endmodule

// *** rtl/spl_pkg.sv ***
package spl_pkg;

  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int unsigned NIB_W    = 4;
  localparam int unsigned ADDR_W   = 5;
  localparam int unsigned CFG_W    = 3;

  // ------------------------------------------------------------
  // strap field positions
  // ------------------------------------------------------------
  localparam int unsigned CFG_BIT0 = 0;
  localparam int unsigned CFG_BIT1 = 1;
  localparam int unsigned CFG_BIT2 = 2;
  localparam int unsigned PA_BIT0  = 0;
  localparam int unsigned PA_BIT1  = 1;
  localparam int unsigned PA_BIT2  = 2;
  localparam int unsigned RXD_B1   = 1;
  localparam int unsigned RXD_B2   = 2;
  localparam int unsigned RXD_B3   = 3;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [NIB_W-1:0]  NIB_ZERO  = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 5'h00;
  localparam logic [CFG_W-1:0]  CFG_ZERO  = 3'h0;

  // ------------------------------------------------------------
  // register bus
  // ------------------------------------------------------------
  localparam int unsigned REG_AW   = 4;
  localparam int unsigned REG_DW   = 32;
  localparam logic [REG_AW-1:0] REG_STRAP  = 4'h0;
  localparam logic [REG_AW-1:0] REG_CTRL   = 4'h4;
  localparam logic [REG_AW-1:0] REG_STATUS = 4'h8;
  localparam logic [REG_DW-1:0] DATA_ZERO  = 32'h0000_0000;
  localparam int unsigned CTRL_MDIX = 0;
  localparam int unsigned CTRL_PA_HI_LSB = 1;
  localparam int unsigned ST_PHASE = 0;

  typedef enum logic [1:0] {
    SPL_STRAP = 2'b00,
    SPL_ARM   = 2'b01,
    SPL_RUN   = 2'b10
  } spl_phase_t;

endpackage

// *** rtl/spl_sync.sv ***
`timescale 1ns/100ps
module spl_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;

  // first stage feeds only the second
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule

// *** sim/spl_top_props.sv ***
`timescale 1ns/100ps
module spl_top_props
  import spl_pkg::*;
(
  input wire logic                       clk,
  input wire logic                       rst_b,
  input wire logic                       rx_link_clk,
  input wire logic                       mdc,
  input wire logic [spl_pkg::REG_AW-1:0] reg_addr,
  input wire logic [spl_pkg::REG_DW-1:0] reg_wdata,
  input wire logic                       reg_wr,
  input wire logic                       reg_rd,
  input wire logic [spl_pkg::REG_DW-1:0] reg_rdata,
  input wire logic [spl_pkg::NIB_W-1:0]  line_rx_nib,
  input wire logic                       line_rx_valid,
  input wire logic                       line_rx_err,
  input wire logic [spl_pkg::NIB_W-1:0]  rxd_in,
  input wire logic                       rxdv_in,
  input wire logic                       rxer_in,
  input wire logic                       rxc_in,
  input wire logic                       crs_in,
  input wire logic [spl_pkg::NIB_W-1:0]  rxd_out,
  input wire logic                       rxdv_out,
  input wire logic                       rxdv_oe_b,
  input wire logic                       rxer_out,
  input wire logic                       rxer_oe_b,
  input wire logic                       pair_a_is_tx,
  input wire logic                       pair_b_is_tx,
  input wire logic                       mdio_in,
  input wire logic                       mdio_sample,
  input wire logic                       mdio_tx_bit,
  input wire logic                       mdio_tx_en,
  input wire logic                       mdio_out,
  input wire logic                       mdio_oe_b,
  input wire logic                       line_carrier,
  input wire logic                       crs_out,
  input wire logic                       crs_oe_b,
  input wire logic                       emission_filter_strap,
  input wire logic [spl_pkg::CFG_W-1:0]  config_strap,
  input wire logic [spl_pkg::ADDR_W-1:0] management_phy_address
);
  import spl_pkg::*;
  // ------------------------------------------------------------
  // cycles since reset release, saturating
  // ------------------------------------------------------------
  logic [2:0] run_cnt_reg;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      run_cnt_reg <= 3'h0;
    end else if (run_cnt_reg != 3'h7) begin
      run_cnt_reg <= run_cnt_reg + 3'h1;
    end
  end
  property p_oe_hold;
    @(posedge clk) disable iff (!rst_b) run_cnt_reg < 3'h3 |-> rxdv_oe_b && rxer_oe_b;
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("strap pin driven too early");
  property p_strap;
    @(posedge clk) disable iff (!rst_b) run_cnt_reg == 3'h4 |->
      emission_filter_strap == $past(rxer_in, 2) && config_strap == $past({rxdv_in, crs_in, rxc_in}, 2) &&
      management_phy_address[2:0] == $past({rxd_in[1], rxd_in[2], rxd_in[3]}, 2);
  endproperty
  a_strap: assert property (p_strap) else $error("strap capture wrong");
  property p_keep;
    @(posedge clk) disable iff (!rst_b) run_cnt_reg == 3'h7 |->
      $stable({emission_filter_strap, config_strap, management_phy_address[2:0]});
  endproperty
  a_keep: assert property (p_keep) else $error("strap changed in run");
  property p_follow;
    @(posedge rx_link_clk) disable iff (!rst_b) !rxdv_oe_b && $past(!rxdv_oe_b, 2) |->
      rxdv_out == $past(line_rx_valid) && rxer_out == $past(line_rx_err) && (!rxdv_out || rxd_out == $past(line_rx_nib));
  endproperty
  a_follow: assert property (p_follow) else $error("receive outputs do not follow link");
  property p_pair;
    @(posedge clk) disable iff (!rst_b) pair_a_is_tx != pair_b_is_tx;
  endproperty
  a_pair: assert property (p_pair) else $error("pair roles not exclusive");
  property p_mdix;
    @(posedge clk) disable iff (!rst_b) reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_MDIX] |-> ##[1:3] pair_b_is_tx;
  endproperty
  a_mdix: assert property (p_mdix) else $error("crossover not applied");
  property p_rd_strap;
    @(posedge clk) disable iff (!rst_b) reg_rd && reg_addr == REG_STRAP |=>
      reg_rdata[8:0] == {management_phy_address, config_strap, emission_filter_strap};
  endproperty
  a_rd_strap: assert property (p_rd_strap) else $error("strap read wrong");
  property p_rd_zero;
    @(posedge clk) disable iff (!rst_b)
      !(reg_rd && (reg_addr == REG_STRAP || reg_addr == REG_CTRL || reg_addr == REG_STATUS)) |=> reg_rdata == DATA_ZERO;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("read data not zero");
  property p_mdio;
    @(posedge mdc) disable iff (!rst_b) $past(rst_b) |-> mdio_sample == $past(mdio_in);
  endproperty
  a_mdio: assert property (p_mdio) else $error("management data not taken on mdc");
  property p_mdio_drive;
    @(posedge mdc) disable iff (!rst_b) $past(rst_b) |->
      mdio_out == $past(mdio_tx_bit) && mdio_oe_b == !$past(mdio_tx_en);
  endproperty
  a_mdio_drive: assert property (p_mdio_drive) else $error("management data not driven on mdc");
  property p_crs;
    @(posedge rx_link_clk) disable iff (!rst_b) !crs_oe_b && $past(!crs_oe_b, 2) |->
      crs_out == $past(line_carrier);
  endproperty
  a_crs: assert property (p_crs) else $error("carrier output does not follow link");
endmodule
bind spl_top spl_top_props spl_top_props_i (.*);

// *** sim/spl_mac_model.sv ***
`timescale 1ns/100ps
module spl_mac_model (
  input  wire logic                      rx_link_clk,
  input  wire logic                      live,
  input  wire logic [spl_pkg::NIB_W-1:0] rxd,
  input  wire logic                      rxdv,
  output logic                           got,
  output logic      [spl_pkg::NIB_W-1:0] nib
);
  // the mac only listens inside a traffic window, so strap pulls are not taken as data
  always_ff @(posedge rx_link_clk) begin
    got <= live && rxdv;
    nib <= rxd;
  end
endmodule

// *** sim/testbench.sv ***
`timescale 1ns/100ps
module testbench;
  import spl_pkg::*;
  logic clk = 0, rst_b = 0, rx_link_clk = 0, mdc = 0, reg_wr = 0, reg_rd = 0, pend = 0, got;
  logic line_rx_valid = 0, line_rx_err = 0, line_carrier = 0, mdio_in = 0, mdio_tx_bit = 0, mdio_tx_en = 0;
  logic feed = 0, live = 0, mdix = 0, rxdv_out, rxdv_oe_b, rxer_out, rxer_oe_b, rxc_out, rxc_oe_b, crs_out, crs_oe_b;
  logic pair_a_is_tx, pair_b_is_tx, mdio_out, mdio_oe_b, mdio_sample, emission_filter_strap;
  logic [3:0] reg_addr = 0, line_rx_nib = 0, rxd_out, rxd_oe_b, nib;
  logic [31:0] reg_wdata = 0, reg_rdata, rq[$], checks = 0, miscompares = 0, cyc = 0;
  logic [3:0] nq[$];
  logic [15:0] seed = 16'h0041, r;
  logic [7:0] pu = 8'h00;
  logic [2:0] config_strap;
  logic [4:0] management_phy_address;
  wire [3:0] rxd_in = (rxd_oe_b & pu[3:0]) | (~rxd_oe_b & rxd_out);
  wire rxdv_in = rxdv_oe_b ? pu[4] : rxdv_out;
  wire rxer_in = rxer_oe_b ? pu[5] : rxer_out;
  wire rxc_in = rxc_oe_b ? pu[6] : rxc_out;
  wire crs_in = crs_oe_b ? pu[7] : crs_out;
  spl_top spl_top_i (.*);
  spl_mac_model spl_mac_model_i (.rx_link_clk(rx_link_clk), .live(live), .rxd(rxd_in), .rxdv(rxdv_in), .got(got), .nib(nib));
  always #10 clk = ~clk;
  initial #7 forever #80 rx_link_clk = ~rx_link_clk;
  always #50 mdc = ~mdc;
  function logic [15:0] rnd();
    seed = seed ^ (seed << 7);
    seed = seed ^ (seed >> 9);
    seed = seed ^ (seed << 8);
    return seed;
  endfunction
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks = checks + 1;
    if (s !== e) begin
      miscompares = miscompares + 1;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    if (!w) rq.push_back(d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask
  // expected strap word: address above config above filter bit
  function logic [31:0] sw();
    return {25'h0, pu[1], pu[2], pu[3], pu[4], pu[7], pu[6], pu[5]};
  endfunction
  task automatic chk_straps();
    chk("filter", {31'h0, emission_filter_strap}, {31'h0, pu[5]});
    chk("config", {29'h0, config_strap}, {29'h0, pu[4], pu[7], pu[6]});
    chk("addr", {27'h0, management_phy_address}, {29'h0, pu[1], pu[2], pu[3]});
  endtask
  always @(posedge clk) begin
    if (pend) chk("reg_rdata", reg_rdata, rq.pop_front());
    pend <= reg_rd;
    cyc <= cyc + 1;
    if (cyc == 32'd6000) begin
      miscompares = miscompares + 1;
      give_verdict();
    end
  end
  always @(posedge rx_link_clk) begin
    if (got === 1'b1) chk("rxd", {28'h0, nib}, {28'h0, nq.pop_front()});
    r = rnd();
    line_rx_valid <= feed & r[0];
    line_rx_nib <= r[7:4];
    line_rx_err <= feed & r[0] & r[1];
    line_carrier <= feed & r[2];
    if (feed & r[0]) nq.push_back(r[7:4]);
  end
  always @(negedge mdc) {mdio_in, mdio_tx_bit, mdio_tx_en} <= rnd();
  initial begin
    repeat (3) begin
      @(posedge clk);
      rst_b <= 1'b0;
      pu <= rnd();
      mdix <= ~mdix;
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      repeat (40) @(posedge clk);
      chk_straps();
      acc(1'b1, REG_CTRL, {31'h0, mdix});
      acc(1'b0, REG_STRAP, sw());
      acc(1'b0, REG_STATUS, 32'h0000_0002);
      acc(1'b0, 4'hC, DATA_ZERO);
      acc(1'b1, REG_STRAP, 32'hFFFF_FFFF);
      acc(1'b0, REG_STRAP, sw());
      chk("pair_b", {31'h0, pair_b_is_tx}, {31'h0, mdix});
      chk("pair_a", {31'h0, pair_a_is_tx}, {31'h0, ~mdix});
      live <= 1'b1;
      feed <= 1'b1;
      repeat (500) @(posedge clk);
      feed <= 1'b0;
      repeat (100) @(posedge clk);
      live <= 1'b0;
      chk_straps();
      chk("drained", {31'h0, nq.size() == 0}, 32'h0000_0001);
    end
    give_verdict();
  end
endmodule
